// [ecc_selftest_coder.sv]
// Parity based SEC/DED coder over eight data bytes with check byte.
`timescale 1ns/1ps
module ecc_selftest_coder (
   input  wire logic [63:0] data_in,
   input  wire logic [7:0]  check_in,
   output logic      [7:0]  check_out,
   output logic      [63:0] data_fix,
   output logic             single_err,
   output logic             double_err
);
   logic [6:0] syn;
   logic [6:0] pos;
   logic       par;
   always_comb begin
      check_out = 8'h00;
      for (int i = 0; i < 64; i++) begin
         if (data_in[i]) begin
            check_out[6:0] = check_out[6:0] ^ 7'(i + 1);
         end
      end
      check_out[7] = ^{data_in, check_out[6:0]};
   end
   assign syn        = check_out[6:0] ^ check_in[6:0];
   assign pos        = syn - 7'h01;
   // Parity over the whole received word, so any single flip reads odd.
   assign par        = ^{data_in, check_in};
   assign single_err = par && (syn[6:0] != 7'h00);
   assign double_err = !par && (syn[6:0] != 7'h00);
   always_comb begin
      data_fix = data_in;
      if (single_err && syn[6:0] <= 7'd64) begin
         data_fix[pos[5:0]] = ~data_in[pos[5:0]];
      end
   end
endmodule : ecc_selftest_coder

// [ecc_selftest_control.sv]
// ECC self-test controller with register port, fault flags and interrupt.
//
// Functional notes
// - Decoder test with selector 0 corrects one error, sets the single flag and outputs fixed data.
// - Decoder test with selector 1 detects two errors and sets the double flag; output is meaningless.
// - The decoder selector is ignored in manual mode and in encoder tests.
// - Coder selector 0 runs the decoder test and 1 runs the encoder test.
// - Enable 1 starts the configured test; 0 keeps normal operation.
// - Hardware never clears the enable bit.
// - Manual encoder test uses bytes 0 to 7; decoder test uses bytes 0 to 8.
`timescale 1ns/1ps
module ecc_selftest_control (
   input  wire logic        SYS_CLK,
   input  wire logic        RSTN,
   input  wire logic [8:0]  ADDR,
   input  wire logic [7:0]  WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [7:0]  RDATA,
   output logic             TEST_ACTIVE,
   output logic             IRQ
);
   logic [7:0]  ctrl_q;
   logic        en_prev_q;
   logic [7:0]  fault_q;
   logic [7:0]  fault_d;
   logic [7:0]  stat_q;
   logic [7:0]  mask_q;
   logic [63:0] dout_q;
   logic [7:0]  rdata_q;
   logic        irq_q;
   logic        active_q;
   logic [71:0] din_bytes;
   logic [63:0] auto_data;
   logic [63:0] coder_data;
   logic [7:0]  coder_check;
   logic [7:0]  enc_check;
   logic [63:0] dec_fix;
   logic        dec_single;
   logic        dec_double;
   logic [7:0]  rd_mux;
   logic [63:0] dout_d;

   wire wr_ctrl  = WR && (ADDR == ecc_selftest_pkg::CTRL_ADDR);
   wire wr_stat  = WR && (ADDR == ecc_selftest_pkg::INT_STAT_ADDR);
   wire wr_mask  = WR && (ADDR == ecc_selftest_pkg::INT_MASK_ADDR);
   wire enable   = ctrl_q[ecc_selftest_pkg::ENABLE_BIT];
   wire encoder  = ctrl_q[ecc_selftest_pkg::CODER_BIT];
   wire manual   = ctrl_q[ecc_selftest_pkg::SOURCE_BIT];
   wire ded_mode = ctrl_q[ecc_selftest_pkg::DECSEL_BIT] &&
                   !manual && !encoder;
   wire start    = enable && !en_prev_q;

   ecc_selftest_regs u_regs (
      .clk     (SYS_CLK),
      .rst_n   (RSTN),
      .wr_en   (WR),
      .addr    (ADDR),
      .wdata   (WDATA),
      .bytes_q (din_bytes)
   );

   genvar g;
   generate
      for (g = 0; g < ecc_selftest_pkg::ENC_BYTES; g++) begin : gen_auto
         assign auto_data[g*8 +: 8] = ecc_selftest_pkg::AUTO_SEED ^ 8'(g);
      end
   endgenerate

   // Manual mode feeds bytes 0..7 as data and byte 8 as check to decoder.
   assign coder_data = manual ? din_bytes[63:0] : auto_data;
   wire [7:0] auto_check;
   wire [63:0] auto_err = ded_mode ? 64'h0000_0000_0000_0003 :
                                     64'h0000_0000_0000_0001;
   wire [63:0] dec_in   = (manual || encoder) ? coder_data :
                                                (coder_data ^ auto_err);

   ecc_selftest_coder u_enc (
      .data_in    (auto_data),
      .check_in   (8'h00),
      .check_out  (auto_check),
      .data_fix   (),
      .single_err (),
      .double_err ()
   );

   assign coder_check = manual ? din_bytes[71:64] : auto_check;

   ecc_selftest_coder u_dec (
      .data_in    (dec_in),
      .check_in   (coder_check),
      .check_out  (enc_check),
      .data_fix   (dec_fix),
      .single_err (dec_single),
      .double_err (dec_double)
   );

   // Encoder output puts the check byte in byte 0; decoder outputs fixed data.
   assign dout_d = encoder ? {56'h0000_0000_0000_00, enc_check} :
                             dec_fix;

   always_comb begin
      fault_d = 8'h00;
      fault_d[ecc_selftest_pkg::DONE_FLAG_BIT] = 1'b1;
      if (!encoder) begin
         fault_d[ecc_selftest_pkg::SEC_FLAG_BIT] = dec_single;
         fault_d[ecc_selftest_pkg::DED_FLAG_BIT] = dec_double;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         ctrl_q <= ecc_selftest_pkg::RESET_VAL;
      end else if (wr_ctrl) begin
         ctrl_q <= WDATA & ecc_selftest_pkg::CTRL_WMASK;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         en_prev_q <= 1'b0;
         active_q  <= 1'b0;
      end else begin
         en_prev_q <= enable;
         active_q  <= enable;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         fault_q <= ecc_selftest_pkg::RESET_VAL;
         dout_q  <= 64'h0000_0000_0000_0000;
      end else if (start) begin
         fault_q <= fault_d;
         dout_q  <= dout_d;
      end
   end

   // Sticky status: set wins over a write-one clear in the same cycle.
   wire [7:0] stat_set = start ? fault_d : 8'h00;
   wire [7:0] stat_clr = wr_stat ? (WDATA & ecc_selftest_pkg::STAT_WMASK) :
                                   8'h00;

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         stat_q <= ecc_selftest_pkg::RESET_VAL;
         mask_q <= ecc_selftest_pkg::RESET_VAL;
         irq_q  <= 1'b0;
      end else begin
         stat_q <= (stat_q & ~stat_clr) | stat_set;
         if (wr_mask) begin
            mask_q <= WDATA & ecc_selftest_pkg::STAT_WMASK;
         end
         irq_q <= |(((stat_q & ~stat_clr) | stat_set) &
                    (wr_mask ? WDATA : mask_q));
      end
   end

   wire [8:0] din_off  = ADDR - ecc_selftest_pkg::DIN_BASE_ADDR;
   wire [8:0] dout_off = ADDR - ecc_selftest_pkg::DOUT_BASE_ADDR;

   always_comb begin
      rd_mux = 8'h00;
      if (ADDR == ecc_selftest_pkg::CTRL_ADDR) begin
         rd_mux = ctrl_q;
      end else if (din_off < 9'(ecc_selftest_pkg::NUM_DIN)) begin
         rd_mux = din_bytes[din_off[3:0]*8 +: 8];
      end else if (dout_off < 9'(ecc_selftest_pkg::NUM_DOUT)) begin
         rd_mux = dout_q[dout_off[2:0]*8 +: 8];
      end else if (ADDR == ecc_selftest_pkg::FAULT_ADDR) begin
         rd_mux = fault_q;
      end else if (ADDR == ecc_selftest_pkg::INT_STAT_ADDR) begin
         rd_mux = stat_q;
      end else if (ADDR == ecc_selftest_pkg::INT_MASK_ADDR) begin
         rd_mux = mask_q;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= RD ? rd_mux : 8'h00;
      end
   end

   assign RDATA       = rdata_q;
   assign TEST_ACTIVE = active_q;
   assign IRQ         = irq_q;
endmodule : ecc_selftest_control

// [ecc_selftest_control_assertions.sv]
// Checker with concurrent assertions for the ECC self-test controller.
`timescale 1ns/1ps
module ecc_selftest_checker (
   input wire logic       SYS_CLK,
   input wire logic       RSTN,
   input wire logic [8:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic       WR,
   input wire logic       RD,
   input wire logic [7:0] RDATA,
   input wire logic       TEST_ACTIVE,
   input wire logic       IRQ
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RSTN);
   wire wr_ctl = WR && ADDR == ecc_selftest_pkg::CTRL_ADDR;
   wire en_on  = wr_ctl && WDATA[0];
   wire en_off = wr_ctl && !WDATA[0];
   wire rd_ctl = RD && ADDR == ecc_selftest_pkg::CTRL_ADDR;
   wire rd_flt = RD && ADDR == ecc_selftest_pkg::FAULT_ADDR;
   wire rd_st  = RD && ADDR == ecc_selftest_pkg::INT_STAT_ADDR;
   property p_idle; !RD |=> RDATA == 8'h00; endproperty
   property p_unmap; RD && ADDR == 9'h1FF |=> RDATA == 8'h00; endproperty
   property p_ctl_rsvd; rd_ctl |=> RDATA[7:4] == 4'h0; endproperty
   property p_flt_rsvd; rd_flt |=> RDATA[7:3] == 5'h00; endproperty
   property p_st_rsvd; rd_st |=> RDATA[7:3] == 5'h00; endproperty
   property p_start; en_on |-> ##[1:2] TEST_ACTIVE; endproperty
   property p_keep;
      $fell(TEST_ACTIVE) |-> $past(en_off) || $past(en_off, 2);
   endproperty
   property p_rise;
      $rose(TEST_ACTIVE) |-> $past(en_on) || $past(en_on, 2);
   endproperty
   a_idle: assert property (p_idle) else $error("stray read data");
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("ctrl rsvd");
   a_flt_rsvd: assert property (p_flt_rsvd) else $error("fault rsvd");
   a_st_rsvd: assert property (p_st_rsvd) else $error("status rsvd");
   a_start: assert property (p_start) else $error("no start");
   a_keep: assert property (p_keep) else $error("enable cleared");
   a_rise: assert property (p_rise) else $error("stray start");
   c_on: cover property (en_on);
   c_flt: cover property (rd_flt);
   c_irq: cover property ($rose(IRQ));
endmodule : ecc_selftest_checker

bind ecc_selftest_control ecc_selftest_checker u_ecc_selftest_checker (
   .SYS_CLK, .RSTN, .ADDR, .WDATA, .WR, .RD, .RDATA, .TEST_ACTIVE, .IRQ);

// [ecc_selftest_pkg.sv]
// Package with register map, field positions and constants for the ECC self-test.
package ecc_selftest_pkg;
   localparam int          ADDR_W          = 9;
   localparam logic [8:0]  CTRL_ADDR       = 9'h011D;
   localparam logic [8:0]  DIN_BASE_ADDR   = 9'h011E;
   localparam logic [8:0]  DOUT_BASE_ADDR  = 9'h0130;
   localparam logic [8:0]  FAULT_ADDR      = 9'h0140;
   localparam logic [8:0]  INT_STAT_ADDR   = 9'h0141;
   localparam logic [8:0]  INT_MASK_ADDR   = 9'h0142;
   localparam int          NUM_DIN         = 9;
   localparam int          NUM_DOUT        = 8;
   localparam int          ENC_BYTES       = 8;
   localparam int          ENABLE_BIT      = 0;
   localparam int          CODER_BIT       = 1;
   localparam int          SOURCE_BIT      = 2;
   localparam int          DECSEL_BIT      = 3;
   localparam logic [7:0]  CTRL_WMASK      = 8'h0F;
   localparam logic [7:0]  RESET_VAL       = 8'h00;
   localparam int          SEC_FLAG_BIT    = 0;
   localparam int          DED_FLAG_BIT    = 1;
   localparam int          DONE_FLAG_BIT   = 2;
   localparam logic [7:0]  AUTO_SEED       = 8'h0A5;
   localparam logic [7:0]  STAT_WMASK      = 8'h07;
endpackage : ecc_selftest_pkg

// [ecc_selftest_regs.sv]
// Self-test input byte registers written by software.
`timescale 1ns/1ps
module ecc_selftest_regs (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        wr_en,
   input  wire logic [8:0]  addr,
   input  wire logic [7:0]  wdata,
   output logic      [71:0] bytes_q
);
   genvar g;
   generate
      for (g = 0; g < ecc_selftest_pkg::NUM_DIN; g++) begin : gen_din
         wire hit = wr_en &&
            (addr == ecc_selftest_pkg::DIN_BASE_ADDR + 9'(g));
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               bytes_q[g*8 +: 8] <= ecc_selftest_pkg::RESET_VAL;
            end else if (hit) begin
               bytes_q[g*8 +: 8] <= wdata;
            end
         end
      end
   endgenerate
endmodule : ecc_selftest_regs

// [tb_ecc_selftest_control.sv]
// Self-checking testbench for the ECC self-test controller.
`timescale 1ns/1ps
module tb_ecc_selftest_control;
   logic       SYS_CLK  = 1'b0;
   logic       RSTN     = 1'b0;
   logic [8:0] ADDR     = 9'h000;
   logic [7:0] WDATA    = 8'h00;
   logic       WR       = 1'b0;
   logic       RD       = 1'b0;
   logic [7:0] RDATA;
   logic       TEST_ACTIVE;
   logic       IRQ;
   int         n_errors = 0;
   int         compares = 0;
   int         cycles   = 0;
   localparam logic [8:0] ad_ct = ecc_selftest_pkg::CTRL_ADDR;
   localparam logic [8:0] ad_fa = ecc_selftest_pkg::FAULT_ADDR;
   localparam logic [8:0] ad_di = ecc_selftest_pkg::DIN_BASE_ADDR;
   localparam logic [8:0] ad_do = ecc_selftest_pkg::DOUT_BASE_ADDR;
   localparam logic [8:0] ad_st = ecc_selftest_pkg::INT_STAT_ADDR;
   localparam logic [8:0] ad_mk = ecc_selftest_pkg::INT_MASK_ADDR;
   always #5 SYS_CLK = ~SYS_CLK;
   ecc_selftest_control u_ecc_selftest_control (.SYS_CLK, .RSTN, .ADDR,
      .WDATA, .WR, .RD, .RDATA, .TEST_ACTIVE, .IRQ);
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge SYS_CLK);
      ADDR  <= a;
      WDATA <= d;
      WR    <= 1'b1;
      @(posedge SYS_CLK);
      WR <= 1'b0;
   endtask : wr
   task automatic rd(input logic [8:0] a, input logic [7:0] exp);
      @(posedge SYS_CLK);
      ADDR <= a;
      RD   <= 1'b1;
      @(posedge SYS_CLK);
      RD <= 1'b0;
      #1;
      chk(RDATA, exp);
   endtask : rd
   task automatic settle;
      repeat (2) @(posedge SYS_CLK);
      #1;
   endtask : settle
   task automatic give_verdict;
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : give_verdict
   always @(posedge SYS_CLK) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         n_errors++;
         give_verdict();
      end
   end
   initial begin
      repeat (12) @(posedge SYS_CLK);
      RSTN <= 1'b1;
      rd(ad_ct, 8'h00);
      rd(ad_di, 8'h00);
      rd(ad_fa, 8'h00);
      wr(9'h1FF, 8'hFF);
      rd(9'h1FF, 8'h00);
      wr(ad_ct, 8'hFE);
      rd(ad_ct, 8'h0E);
      chk({7'h00, TEST_ACTIVE}, 8'h00);
      $display("test reset done");
      wr(ad_di, 8'h04);
      wr(ad_di + 9'd8, 8'hFF);
      wr(ad_ct, 8'h0F);
      rd(ad_do, 8'h83);
      rd(ad_do + 9'd1, 8'h00);
      rd(ad_fa, 8'h04);
      rd(ad_ct, 8'h0F);
      chk({7'h00, TEST_ACTIVE}, 8'h01);
      $display("test encoder done");
      wr(ad_ct, 8'h00);
      wr(ad_di, 8'h00);
      wr(ad_di + 9'd8, 8'h83);
      wr(ad_ct, 8'h0D);
      rd(ad_fa, 8'h05);
      rd(ad_do, 8'h04);
      wr(ad_ct, 8'h09);
      rd(ad_fa, 8'h05);
      for (int s = 0; s < 2; s++) begin
         wr(ad_ct, 8'h00);
         settle();
         chk({7'h00, TEST_ACTIVE}, 8'h00);
         wr(ad_ct, 8'h01 | 8'(s << 3));
         rd(ad_fa, 8'h05 + 8'(s));
         if (s == 0) rd(ad_do, 8'hA5);
      end
      $display("test decoder done");
      wr(ad_ct, 8'h00);
      wr(ad_ct, 8'h03);
      rd(ad_do, 8'hC0);
      rd(ad_fa, 8'h04);
      $display("test auto encoder done");
      chk({7'h00, IRQ}, 8'h00);
      wr(ad_mk, 8'h02);
      settle();
      chk({7'h00, IRQ}, 8'h01);
      wr(ad_st, 8'h02);
      settle();
      chk({7'h00, IRQ}, 8'h00);
      rd(ad_st, 8'h05);
      rd(ad_mk, 8'h02);
      $display("test interrupt done");
      give_verdict();
   end
endmodule : tb_ecc_selftest_control
